// file: src/adc_serial_port.sv
// Slave serial port carrying the conversion result out and the control byte in
// Summary of operation
// - Five-line form: separate data out and in
// - Slave only; host supplies serial clock
// - Direction rise presents MSB; later bits falling
// - Ten result bits; host may stop at eight
// - Output released on direction fall, or on select rise in five-line form
// - Read erases result until new conversion
// - Control byte from first eight rising edges
// - Data in and out may share one line
// - Three-line form: one two-way data pin
// - Three-line read drives pin, shifts from second fall
// - Three-line pin returns to input on direction fall
// - Result is straight unsigned binary
// - Channel select powers up at channel 0
`timescale 1ns/1ps
`default_nettype none
module adc_serial_port (
  input wire logic i_core_clk, // Core clock, 25 MHz
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_three_wire, // Static strap: 1 selects shared data pin
  input wire logic i_sclk, // Serial clock from host
  input wire logic i_rd_wr, // Direction: high read, low write
  input wire logic i_select_n, // Interface select, active low
  input wire logic i_din, // Serial data in (five-line form)
  input wire logic i_dio_in, // Shared pin input level (three-line form)
  input wire logic i_result_valid, // Pulse: new conversion result ready
  input wire logic [9:0] i_result, // Straight binary conversion result
  output logic o_dout, // Serial data out value
  output logic o_dout_oe_n, // Data out enable, low drives
  output logic o_dio_out, // Shared pin output value
  output logic o_dio_oe_n, // Shared pin enable, low drives
  output logic [7:0] o_control, // Last control byte written
  output logic [2:0] o_channel, // Channel field of control byte
  output logic o_control_strobe, // Pulse: control byte complete
  output logic o_result_full // A result awaits reading
);
  typedef enum logic [1:0] {IDLE, READ, WRITE} state_t;

  state_t state, next_state;
  logic sclk_rise, sclk_fall;
  logic dir_rise, dir_fall;
  logic sel_lvl, sel_rise;
  logic din_lvl, dio_lvl;
  logic [9:0] result;
  logic full;
  logic [9:0] shift;
  logic [3:0] count;
  logic skip_fall;
  logic [7:0] control;
  logic [7:0] ctrl_shift;
  logic strobe;
  logic drive;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Host clock idles high, so no false edge follows reset
  pin_sync u_sclk (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_pin(i_sclk),
    .i_init(1'b1), .o_level(), .o_rise(sclk_rise), .o_fall(sclk_fall));
  pin_sync u_dir (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_pin(i_rd_wr),
    .i_init(1'b0), .o_level(), .o_rise(dir_rise), .o_fall(dir_fall));
  pin_sync u_sel (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_pin(i_select_n),
    .i_init(1'b1), .o_level(sel_lvl), .o_rise(sel_rise), .o_fall());
  pin_sync u_din (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_pin(i_din),
    .i_init(1'b0), .o_level(din_lvl), .o_rise(), .o_fall());
  pin_sync u_dio (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_pin(i_dio_in),
    .i_init(1'b0), .o_level(dio_lvl), .o_rise(), .o_fall());

  // ****************************************
  // Decode
  // ****************************************
  wire selected = i_three_wire | ~sel_lvl;
  wire data_in = i_three_wire ? dio_lvl : din_lvl;
  wire start_read = dir_rise & selected;
  wire start_write = dir_fall & selected;
  wire end_read = (state == READ) & (dir_fall | (~i_three_wire & sel_rise));
  wire take_bit = (state == WRITE) & sclk_rise & (count < serial_port_pkg::CTRL_COUNT);
  wire shift_bit = (state == READ) & sclk_fall & ~skip_fall
    & (count < serial_port_pkg::RESULT_LAST);
  wire ctrl_done = take_bit & (count == serial_port_pkg::CTRL_COUNT - 4'h1);
  wire [7:0] next_ctrl_shift = {ctrl_shift[6:0], data_in};

  always_comb begin
    next_state = state;
    unique case (state)
      IDLE: begin
        if (start_read) begin
          next_state = READ;
        end else if (start_write) begin
          next_state = WRITE;
        end
      end
      READ: begin
        if (end_read) begin
          next_state = start_write ? WRITE : IDLE;
        end
      end
      WRITE: begin
        if (start_read) begin
          next_state = READ;
        end else if (~i_three_wire & sel_rise) begin
          next_state = IDLE;
        end
      end
      default: begin
        next_state = IDLE;
      end
    endcase
  end

  // ****************************************
  // Sequencer and shift registers
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      shift <= serial_port_pkg::RESULT_EMPTY;
      count <= serial_port_pkg::BIT_COUNT_ZERO;
      skip_fall <= 1'b0;
    end else if (start_read | start_write) begin
      shift <= full ? result : serial_port_pkg::RESULT_EMPTY;
      count <= serial_port_pkg::BIT_COUNT_ZERO;
      skip_fall <= 1'b1;
    end else if (shift_bit) begin
      shift <= {shift[8:0], 1'b0};
      count <= count + 4'h1;
    end else if (take_bit) begin
      count <= count + 4'h1;
    end else if (sclk_fall) begin
      skip_fall <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_shift <= serial_port_pkg::CTRL_RESET;
      control <= serial_port_pkg::CTRL_RESET;
      strobe <= 1'b0;
    end else begin
      strobe <= ctrl_done;
      if (take_bit) begin
        ctrl_shift <= next_ctrl_shift;
      end
      if (ctrl_done) begin
        control <= next_ctrl_shift;
      end
    end
  end

  // New result wins over erasure in the same cycle
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      full <= 1'b0;
      result <= serial_port_pkg::RESULT_EMPTY;
    end else if (i_result_valid) begin
      full <= 1'b1;
      result <= i_result;
    end else if (start_read) begin
      full <= 1'b0;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign drive = (state == READ);
  assign o_dout = shift[9];
  assign o_dout_oe_n = ~(drive & ~i_three_wire);
  assign o_dio_out = shift[9];
  assign o_dio_oe_n = ~(drive & i_three_wire);
  assign o_control = control;
  assign o_channel = control[serial_port_pkg::CHAN_MSB:serial_port_pkg::CHAN_LSB];
  assign o_control_strobe = strobe;
  assign o_result_full = full;

  // ****************************************
  // Checks
  // ****************************************
  chk_read_drives: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    start_read |=> (o_dout_oe_n == i_three_wire) && (o_dio_oe_n == ~i_three_wire))
    else $error("read did not enable output");
  chk_release_dir: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (state == READ) && dir_fall |=> o_dout_oe_n && o_dio_oe_n)
    else $error("output not released on direction fall");
  chk_release_sel: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (state == READ) && !i_three_wire && sel_rise |=> o_dout_oe_n)
    else $error("output not released on select rise");
  chk_read_erases: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    start_read && !i_result_valid |=> !o_result_full)
    else $error("result not erased by read");
  chk_first_fall_skip: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (state == READ) && skip_fall && sclk_fall && !dir_fall |=> $stable(o_dout))
    else $error("first falling edge shifted");
  chk_msb_shift: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    shift_bit |=> o_dout == $past(shift[8]))
    else $error("shift order wrong");
  chk_ctrl_stable: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !ctrl_done |=> $stable(o_control))
    else $error("control changed outside write");
  chk_ctrl_strobe: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    ctrl_done |=> o_control_strobe ##1 !o_control_strobe)
    else $error("control strobe wrong");
  cov_read: cover property (@(posedge i_core_clk) disable iff (!i_resetn)
    start_read ##[1:1000] end_read);
  cov_write: cover property (@(posedge i_core_clk) disable iff (!i_resetn) ctrl_done);
  cov_three_read: cover property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_three_wire && start_read);
endmodule
`default_nettype wire

// file: src/pin_sync.sv
// Two-stage synchroniser with edge detection for one external pin
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic i_core_clk, // Core clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_pin, // Raw pin level
  input wire logic i_init, // Level assumed before reset release
  output logic o_level, // Synchronised level
  output logic o_rise, // One-cycle rising pulse
  output logic o_fall // One-cycle falling pulse
);
  logic [1:0] stage;
  logic last;
  logic [1:0] primed;

  // First stage feeds the second only
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stage <= serial_port_pkg::SYNC_RESET;
    end else begin
      stage <= {stage[0], i_pin};
    end
  end

  // Edge history starts from the second stage once it holds real data
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      last <= 1'b0;
      primed <= serial_port_pkg::SYNC_RESET;
    end else begin
      // Assumed level stands in until the second stage has real pin data
      last <= primed[1] ? stage[1] : i_init;
      primed <= {primed[0], 1'b1};
    end
  end

  assign o_level = stage[1];
  assign o_rise = primed[1] & stage[1] & ~last;
  assign o_fall = primed[1] & ~stage[1] & last;
endmodule
`default_nettype wire

// file: src/serial_port_pkg.sv
// Constants shared by the converter serial result and control port
package serial_port_pkg;
  localparam int RESULT_BITS = 10;
  localparam int CTRL_BITS = 8;
  localparam logic [3:0] RESULT_LAST = 4'h9;
  localparam logic [3:0] CTRL_COUNT = 4'h8;
  localparam logic [3:0] BIT_COUNT_ZERO = 4'h0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] CHANNEL_TEMP = 3'h0;
  localparam int CHAN_MSB = 7;
  localparam int CHAN_LSB = 5;
  localparam logic [9:0] RESULT_EMPTY = 10'h000;
  localparam logic [1:0] SYNC_RESET = 2'h0;
endpackage

// file: tb/adc_serial_port_tb.sv
// Self-checking bench for the serial result and control port
`timescale 1ns/1ps
`default_nettype none
module adc_serial_port_tb;
  logic core_clk, resetn, three, valid;
  logic [9:0] result, r;
  logic [7:0] b;
  logic dout, dout_oe_n, dio_out, dio_oe_n, strobe, full;
  logic [7:0] control;
  logic [2:0] channel;
  logic sclk, rd_wr, select_n, din, dio, rd_done;
  logic [9:0] rd_val;
  logic [9:0] exp_q[$];
  logic [9:0] e;
  int errors = 0;
  int comparisons = 0;
  int seed = 32'h97b0;
  adc_serial_port dut (.i_core_clk(core_clk), .i_resetn(resetn), .i_three_wire(three),
    .i_sclk(sclk), .i_rd_wr(rd_wr), .i_select_n(select_n), .i_din(din), .i_dio_in(dio),
    .i_result_valid(valid), .i_result(result), .o_dout(dout), .o_dout_oe_n(dout_oe_n),
    .o_dio_out(dio_out), .o_dio_oe_n(dio_oe_n), .o_control(control), .o_channel(channel),
    .o_control_strobe(strobe), .o_result_full(full));
  host_model host (.i_three(three), .i_dout(dout), .i_dout_oe_n(dout_oe_n),
    .i_dio_out(dio_out), .i_dio_oe_n(dio_oe_n), .o_sclk(sclk), .o_rd_wr(rd_wr),
    .o_select_n(select_n), .o_din(din), .o_dio(dio), .o_rd_done(rd_done), .o_rd_val(rd_val));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    check(10'(exp_q.size()), 10'h000);
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ****************************************
  // Control byte and result watcher
  // ****************************************
  always @(posedge core_clk) begin
    if (strobe === 1'b1) begin
      e = exp_q.pop_front();
      check({2'h0, control}, e);
      check({7'h0, channel}, {7'h0, e[7:5]});
    end
    if (rd_done === 1'b1) check(rd_val, exp_q.pop_front());
  end
  task automatic do_reset(input logic t);
    resetn <= 1'b0;
    three <= t;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    check({8'h0, dout_oe_n, dio_oe_n}, 10'h003);
    check({1'h0, full, control}, 10'h000);
    check({7'h0, channel}, 10'h000);
  endtask
  task automatic load(input logic [9:0] v);
    @(posedge core_clk);
    valid <= 1'b1;
    result <= v;
    @(posedge core_clk);
    valid <= 1'b0;
    @(posedge core_clk);
    check({9'h0, full}, 10'h001);
  endtask
  task automatic rd(input int n, input logic sel_end, input logic [9:0] v);
    exp_q.push_back(v);
    host.read_bits(n, sel_end);
    check({9'h0, three ? dio_oe_n : dout_oe_n}, 10'h001);
    check({9'h0, full}, 10'h000);
  endtask
  initial begin
    #500000;
    errors++;
    report_and_stop;
  end
  // ****************************************
  // Main sequence, five-line then three-line form
  // ****************************************
  initial begin
    resetn = 1'b0;
    three = 1'b0;
    valid = 1'b0;
    result = 10'h000;
    for (int m = 0; m < 2; m++) begin
      do_reset(m[0]);
      for (int k = 0; k < 3; k++) begin
        b = 8'($random(seed));
        exp_q.push_back({2'h0, b});
        host.write_byte(b);
      end
      r = 10'($random(seed));
      load(r);
      rd(10, 1'b0, r);
      rd(10, 1'b0, 10'h000);
      r = 10'($random(seed));
      load(r);
      rd(8, m == 0, {2'h0, r[9:2]});
      $display("test form %0d done", m);
    end
    report_and_stop;
  end
endmodule
`default_nettype wire

// file: tb/host_model.sv
// Host model: serial clock, direction, select and data lines of the port
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic i_three, // Shared pin form selected
  input wire logic i_dout, // Device data out
  input wire logic i_dout_oe_n, // Low while device drives data out
  input wire logic i_dio_out, // Device shared pin value
  input wire logic i_dio_oe_n, // Low while device drives shared pin
  output logic o_sclk, // Serial clock, idles high
  output logic o_rd_wr, // Direction, high read
  output logic o_select_n, // Select, active low
  output logic o_din, // Five-line data in
  output logic o_dio, // Resolved shared pin level
  output logic o_rd_done, // Pulse: read finished
  output logic [9:0] o_rd_val // Bits gathered by last read
);
  logic hbit = 1'b0;
  logic hdrv = 1'b0;
  logic flt = 1'b0;
  logic dline;
  // Undriven lines keep changing so stale data never matches
  always #37 flt = ~flt;
  assign o_din = hdrv ? hbit : flt;
  assign o_dio = !i_dio_oe_n ? i_dio_out : (hdrv ? hbit : flt);
  assign dline = i_three ? o_dio : (i_dout_oe_n ? flt : i_dout);
  initial begin
    o_sclk = 1'b1;
    o_rd_wr = 1'b0;
    o_select_n = 1'b1;
    o_rd_done = 1'b0;
    o_rd_val = 10'h000;
  end
  // Direction low then high before each read, held high throughout
  task automatic read_bits(input int n, input logic sel_end);
    #7;
    o_select_n = 1'b0;
    o_rd_wr = 1'b0;
    #320;
    o_rd_wr = 1'b1;
    #320;
    o_rd_val = 10'h000;
    for (int i = 0; i < n; i++) begin
      o_sclk = 1'b0;
      #160;
      o_rd_val = {o_rd_val[8:0], dline};
      o_sclk = 1'b1;
      #160;
    end
    if (sel_end) o_select_n = 1'b1;
    else o_rd_wr = 1'b0;
    o_rd_done = 1'b1;
    #40;
    o_rd_done = 1'b0;
    // Direction back low, after select when the read ended on select, so a later reset sees no stray rise
    o_rd_wr = 1'b0;
    #280;
  endtask
  // Direction high then low before each write; two extra clocks sent
  task automatic write_byte(input logic [7:0] b);
    #7;
    o_select_n = 1'b0;
    o_rd_wr = 1'b1;
    #320;
    o_rd_wr = 1'b0;
    #320;
    hdrv = 1'b1;
    for (int i = 0; i < 10; i++) begin
      hbit = (i < 8) ? b[7-i] : ~b[0];
      o_sclk = 1'b0;
      #160;
      o_sclk = 1'b1;
      #160;
    end
    hdrv = 1'b0;
    #320;
  endtask
endmodule
`default_nettype wire
